/* include/fds_pkg.sv */
package fds_pkg;
	localparam int FDS_NDIV   = 4;
	localparam int FDS_INT_W  = 8;
	localparam int FDS_FRAC_W = 43;
	localparam int FDS_PEND_W = 34;
	localparam int FDS_RES_W  = 66;
	localparam int FDS_SUM_W  = 46;
	// Register offsets inside a unit
	localparam logic [3:0] FDS_R_INT     = 4'h0;
	localparam logic [3:0] FDS_R_FRAC_LO = 4'h1;
	localparam logic [3:0] FDS_R_FRAC_HI = 4'h2;
	localparam logic [3:0] FDS_R_FINE    = 4'h3;
	localparam logic [3:0] FDS_R_RATE    = 4'h4;
	localparam logic [3:0] FDS_R_STAT    = 4'h5;
	localparam logic [3:0] FDS_R_ODIV    = 4'h0;
	localparam logic [3:0] FDS_R_PHIGH   = 4'h1;
	localparam logic [3:0] FDS_R_OCTRL   = 4'h2;
	// Address bit positions
	localparam int FDS_A_STAGE = 6;
	localparam int FDS_A_MAP   = 7;
	// Reset values
	localparam logic [7:0]  FDS_INT_RST   = 8'h14;
	localparam logic [31:0] FDS_ODIV_RST  = 32'h0000_0004;
	localparam logic [31:0] FDS_PHIGH_RST = 32'h0000_0000;
	localparam logic [1:0]  FDS_OCTRL_RST = 2'h0;
	// Rate codes and their ratio offsets per divider period
	localparam logic [1:0]  FDS_RATE_SLOW = 2'h0;
	localparam logic [1:0]  FDS_RATE_MED  = 2'h1;
	localparam logic [1:0]  FDS_RATE_FAST = 2'h2;
	localparam logic [42:0] FDS_OFS_SLOW  = 43'h4_0000_0000;
	localparam logic [42:0] FDS_OFS_MED   = 43'h20_0000_0000;
	localparam logic [42:0] FDS_OFS_FAST  = 43'h100_0000_0000;
	// Synth clock period and fraction units per picosecond
	localparam int FDS_SYN_PERIOD_PS = 4000;
	localparam logic [31:0] FDS_FRAC_PER_PS =
		32'((64'h1 << FDS_FRAC_W) / FDS_SYN_PERIOD_PS);
	typedef enum logic [1:0] {
		FDS_ST_IDLE = 2'b01,
		FDS_ST_STEP = 2'b10
	} fds_step_type;
endpackage

/* include/fds_path_if.sv */
interface fds_path_if;
	logic        tick;
	logic [31:0] div;
	logic [31:0] high;
	logic        inv;
	logic        q;
	logic        qn;
	modport src  (output tick, div, high, inv, input q, qn);
	modport path (input tick, div, high, inv, output q, qn);
endinterface

/* rtl/fds_out_path.sv */
module fds_out_path
	import fds_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	fds_path_if.path  pif
);
	logic [31:0] cnt_ff;
	logic [31:0] hk_ff;
	logic [31:0] ptk_ff;
	logic        q_ff;
	logic        qn_ff;
	logic        armed_ff;
	logic [31:0] div_prev_ff;
	logic [31:0] high_prev_ff;

	// High length; zero count falls back to half period
	wire logic [31:0] hi_len = (pif.high != '0) ? pif.high : (pif.div >> 1);
	wire logic [31:0] wrap = pif.div - 32'h0000_0001;
	wire logic [31:0] nxt_cnt = !pif.tick ? cnt_ff :
		(cnt_ff >= wrap) ? '0 : cnt_ff + 32'h0000_0001;
	// Divisor of 0 or 1 cannot toggle on ticks, so it holds high
	wire logic nxt_q = (pif.div <= 32'h0000_0001) ? 1'b1 : (nxt_cnt < hi_len);
	wire logic nxt_qn = pif.inv ? ~nxt_q : nxt_q;

	// Counter and outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= '0;
			q_ff   <= 1'b0;
			qn_ff  <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			q_ff   <= nxt_q;
			qn_ff  <= nxt_qn;
		end
	end
	assign pif.q  = q_ff;
	assign pif.qn = qn_ff;

	// A settings change spoils the running period, so checks rearm at wrap
	wire logic cfg_chg = (pif.div != div_prev_ff) ||
		(pif.high != high_prev_ff);

	// Helpers for the checks below
	always_ff @(posedge clk) begin
		if (srst) begin
			hk_ff        <= '0;
			ptk_ff       <= '0;
			armed_ff     <= 1'b0;
			div_prev_ff  <= '0;
			high_prev_ff <= '0;
		end else begin
			div_prev_ff  <= pif.div;
			high_prev_ff <= pif.high;
			if (pif.tick) begin
				hk_ff  <= q_ff ? hk_ff + 32'h0000_0001 : 32'h0000_0001;
				ptk_ff <= (nxt_cnt == '0) ? 32'h0000_0001 :
					ptk_ff + 32'h0000_0001;
			end
			if (cfg_chg)
				armed_ff <= 1'b0;
			else if (pif.tick && nxt_cnt == '0)
				armed_ff <= 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_period;
		pif.tick && nxt_cnt == '0 && armed_ff && pif.div > 32'h0000_0001
			&& !cfg_chg |-> ptk_ff == pif.div;
	endproperty
	a_period: assert property (p_period)
		else $error("output period differs from divisor");

	property p_high;
		pif.tick && q_ff && !nxt_q && armed_ff && $stable(pif.high)
			&& !cfg_chg |-> hk_ff == hi_len;
	endproperty
	a_high: assert property (p_high)
		else $error("high time differs from programmed count");

	property p_inv;
		##1 qn_ff == ($past(pif.inv) ? ~q_ff : q_ff);
	endproperty
	a_inv: assert property (p_inv)
		else $error("complementary output polarity wrong");
endmodule // fds_out_path

/* rtl/fds_top.sv */
module fds_top
	import fds_pkg::*;
#(
	parameter int STAGE_COPIES = 1
) (
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        cfg_wr,
	input  wire logic                        cfg_rd,
	input  wire logic [7:0]                  cfg_addr,
	input  wire logic [31:0]                 cfg_wdata,
	output logic      [31:0]                 cfg_rdata,
	output logic                             cfg_rvalid,
	output logic      [FDS_NDIV-1:0]         fb_tick,
	output logic      [4*STAGE_COPIES-1:0]   out_q,
	output logic      [4*STAGE_COPIES-1:0]   out_qn
);
	// Address decode; upper half of the map is unmapped
	wire logic       in_map = !cfg_addr[FDS_A_MAP];
	wire logic       wr_div = cfg_wr && in_map && !cfg_addr[FDS_A_STAGE];
	wire logic       wr_stg = cfg_wr && in_map && cfg_addr[FDS_A_STAGE];
	wire logic [1:0] unit   = cfg_addr[5:4];
	wire logic [3:0] roff   = cfg_addr[3:0];
	wire logic [FDS_PEND_W-1:0] wext = {{2{cfg_wdata[31]}}, cfg_wdata};

	logic [FDS_INT_W-1:0]   int_ff  [FDS_NDIV];
	logic [FDS_FRAC_W-1:0]  frac_ff [FDS_NDIV];
	logic [FDS_FRAC_W-1:0]  acc_ff  [FDS_NDIV];
	logic [1:0]             rate_ff [FDS_NDIV];
	fds_step_type           st_ff   [FDS_NDIV];
	logic                   dir_ff  [FDS_NDIV];
	logic [FDS_RES_W-1:0]   res_ff  [FDS_NDIV];
	logic [FDS_PEND_W-1:0]  pend_ff [FDS_NDIV];
	logic [FDS_INT_W:0]     cnt_ff  [FDS_NDIV];
	logic                   tick_ff [FDS_NDIV];
	logic [31:0]            odiv_ff [4];
	logic [31:0]            phigh_ff[4];
	logic [1:0]             octrl_ff[4];
	logic [31:0]            cfg_rdata_ff;
	logic                   cfg_rvalid_ff;

	for (genvar d = 0; d < FDS_NDIV; d++) begin : g_div
		wire logic hit     = wr_div && unit == 2'(d);
		wire logic fine_wr = hit && roff == FDS_R_FINE;
		wire logic [FDS_FRAC_W-1:0] ofs =
			(rate_ff[d] == FDS_RATE_FAST) ? FDS_OFS_FAST :
			(rate_ff[d] == FDS_RATE_MED)  ? FDS_OFS_MED : FDS_OFS_SLOW;
		// Last portion of a step is trimmed so the shift lands exactly
		wire logic [FDS_FRAC_W-1:0] amt = (res_ff[d] < FDS_RES_W'(ofs)) ?
			res_ff[d][FDS_FRAC_W-1:0] : ofs;
		wire logic [FDS_SUM_W-1:0] amt_x = {3'h0, amt};
		// Delay lengthens the ratio, advance shortens it
		wire logic [FDS_SUM_W-1:0] adj = (st_ff[d] != FDS_ST_STEP) ? '0 :
			dir_ff[d] ? amt_x : -amt_x;
		wire logic [FDS_SUM_W-1:0] sum = {3'h0, acc_ff[d]} +
			{3'h0, frac_ff[d]} + adj;
		wire logic [FDS_INT_W:0] len = {1'b0, int_ff[d]} +
			{{6{sum[45]}}, sum[45:43]};
		wire logic tick_now = cnt_ff[d] == (FDS_INT_W+1)'(1);
		wire logic pend_neg = pend_ff[d][FDS_PEND_W-1];
		wire logic [FDS_PEND_W-1:0] mag = pend_neg ? -pend_ff[d] : pend_ff[d];
		wire logic load = st_ff[d] == FDS_ST_IDLE && pend_ff[d] != '0;
		wire logic step_end = st_ff[d] == FDS_ST_STEP && tick_now &&
			res_ff[d] <= FDS_RES_W'(ofs);

		// Divider configuration
		always_ff @(posedge clk) begin
			if (srst) begin
				int_ff[d]  <= FDS_INT_RST;
				frac_ff[d] <= '0;
				rate_ff[d] <= FDS_RATE_SLOW;
			end else if (hit) begin
				case (roff)
					FDS_R_INT:     int_ff[d] <= cfg_wdata[FDS_INT_W-1:0];
					FDS_R_FRAC_LO: frac_ff[d][31:0] <= cfg_wdata;
					FDS_R_FRAC_HI: frac_ff[d][42:32] <= cfg_wdata[10:0];
					FDS_R_RATE:    rate_ff[d] <= cfg_wdata[1:0];
					default:       ;
				endcase
			end
		end

		// Pending fine adjust sums writes so none is lost while busy
		always_ff @(posedge clk) begin
			if (srst)
				pend_ff[d] <= '0;
			else if (load)
				pend_ff[d] <= fine_wr ? wext : '0;
			else if (fine_wr)
				pend_ff[d] <= pend_ff[d] + wext;
		end

		// Phase step engine; remaining shift kept in fraction units
		always_ff @(posedge clk) begin
			if (srst) begin
				st_ff[d]  <= FDS_ST_IDLE;
				res_ff[d] <= '0;
				dir_ff[d] <= 1'b0;
			end else begin
				case (st_ff[d])
					FDS_ST_IDLE: if (load) begin
						st_ff[d]  <= FDS_ST_STEP;
						res_ff[d] <= {32'h0000_0000, mag} * FDS_FRAC_PER_PS;
						dir_ff[d] <= !pend_neg;
					end
					FDS_ST_STEP: if (tick_now) begin
						res_ff[d] <= res_ff[d] - FDS_RES_W'(amt);
						if (step_end)
							st_ff[d] <= FDS_ST_IDLE;
					end
					default: st_ff[d] <= FDS_ST_IDLE;
				endcase
			end
		end

		// Fractional divide core: period is whole part plus carry
		always_ff @(posedge clk) begin
			if (srst) begin
				acc_ff[d]  <= '0;
				cnt_ff[d]  <= (FDS_INT_W+1)'(1);
				tick_ff[d] <= 1'b0;
			end else begin
				tick_ff[d] <= tick_now;
				if (tick_now) begin
					acc_ff[d] <= sum[FDS_FRAC_W-1:0];
					cnt_ff[d] <= len;
				end else begin
					cnt_ff[d] <= cnt_ff[d] - (FDS_INT_W+1)'(1);
				end
			end
		end
		assign fb_tick[d] = tick_ff[d];
	end

	for (genvar s = 0; s < 4; s++) begin : g_stg
		localparam int PRI = (s == 3) ? 2 : s;
		localparam int ALT = (s == 0) ? 1 : 3;
		localparam bit HAS_SEL = (s == 0) || (s == 3);
		// Stages four and seven pick a source; five and six are fixed
		wire logic stick = (HAS_SEL && octrl_ff[s][0]) ?
			tick_ff[ALT] : tick_ff[PRI];

		// Stage configuration
		always_ff @(posedge clk) begin
			if (srst) begin
				odiv_ff[s]  <= FDS_ODIV_RST;
				phigh_ff[s] <= FDS_PHIGH_RST;
				octrl_ff[s] <= FDS_OCTRL_RST;
			end else if (wr_stg && unit == 2'(s)) begin
				case (roff)
					FDS_R_ODIV:  odiv_ff[s]  <= cfg_wdata;
					FDS_R_PHIGH: phigh_ff[s] <= cfg_wdata;
					FDS_R_OCTRL: octrl_ff[s] <= cfg_wdata[1:0];
					default:     ;
				endcase
			end
		end

		// Copies of a dual stage share source and settings
		for (genvar c = 0; c < STAGE_COPIES; c++) begin : g_cp
			fds_path_if pif ();
			assign pif.tick = stick;
			assign pif.div  = odiv_ff[s];
			assign pif.high = phigh_ff[s];
			assign pif.inv  = octrl_ff[s][1];
			fds_out_path u_path (
				.clk  (clk),
				.srst (srst),
				.pif  (pif)
			);
			assign out_q[s*STAGE_COPIES+c]  = pif.q;
			assign out_qn[s*STAGE_COPIES+c] = pif.qn;
		end
	end

	// Read selection
	wire logic [31:0] rd_div =
		(roff == FDS_R_INT)     ? {24'h00_0000, int_ff[unit]} :
		(roff == FDS_R_FRAC_LO) ? frac_ff[unit][31:0] :
		(roff == FDS_R_FRAC_HI) ? {21'h00_0000, frac_ff[unit][42:32]} :
		(roff == FDS_R_FINE)    ? pend_ff[unit][31:0] :
		(roff == FDS_R_RATE)    ? {30'h0000_0000, rate_ff[unit]} :
		(roff == FDS_R_STAT)    ? {30'h0000_0000, pend_ff[unit] != '0,
			st_ff[unit] == FDS_ST_STEP} : '0;
	wire logic [31:0] rd_stg =
		(roff == FDS_R_ODIV)  ? odiv_ff[unit] :
		(roff == FDS_R_PHIGH) ? phigh_ff[unit] :
		(roff == FDS_R_OCTRL) ? {30'h0000_0000, octrl_ff[unit]} : '0;
	wire logic [31:0] rd_sel = !in_map ? '0 :
		cfg_addr[FDS_A_STAGE] ? rd_stg : rd_div;

	// Read data registered, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_rdata_ff  <= '0;
			cfg_rvalid_ff <= 1'b0;
		end else begin
			cfg_rvalid_ff <= cfg_rd;
			if (cfg_rd)
				cfg_rdata_ff <= rd_sel;
		end
	end
	assign cfg_rdata  = cfg_rdata_ff;
	assign cfg_rvalid = cfg_rvalid_ff;

	// Expected next period for the first divider when not stepping
	wire logic [FDS_FRAC_W:0] exp_s = {1'b0, acc_ff[0]} + {1'b0, frac_ff[0]};
	wire logic [FDS_INT_W:0] exp_len = {1'b0, int_ff[0]} +
		{{FDS_INT_W{1'b0}}, exp_s[FDS_FRAC_W]};
	wire logic idle0 = st_ff[0] == FDS_ST_IDLE;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_ratio;
		g_div[0].tick_now && idle0 |=> cnt_ff[0] == $past(exp_len);
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("divider period not whole part plus carry");

	property p_dir;
		$rose(st_ff[0] == FDS_ST_STEP) |-> dir_ff[0] != $past(g_div[0].pend_neg);
	endproperty
	a_dir: assert property (p_dir)
		else $error("phase step direction wrong");

	property p_step_end;
		g_div[0].step_end |=> idle0 ##1 cnt_ff[0] != '0;
	endproperty
	a_step_end: assert property (p_step_end)
		else $error("phase step did not finish");

	property p_rate;
		st_ff[0] == FDS_ST_STEP && rate_ff[0] == FDS_RATE_FAST &&
			res_ff[0] > FDS_RES_W'(FDS_OFS_FAST)
			|-> g_div[0].amt == FDS_OFS_FAST;
	endproperty
	a_rate: assert property (p_rate)
		else $error("fast rate offset wrong");

	property p_queue;
		g_div[0].fine_wr && !g_div[0].load && cfg_wdata != '0 &&
			pend_ff[0] == '0 |=> pend_ff[0] != '0;
	endproperty
	a_queue: assert property (p_queue)
		else $error("fine adjust write lost");

	property p_src;
		tick_ff[1] && octrl_ff[0][0] |-> g_stg[0].g_cp[0].pif.tick;
	endproperty
	a_src: assert property (p_src)
		else $error("stage four source select ignored");

	c_step: cover property (g_div[0].step_end);
	c_busy_wr: cover property (g_div[0].fine_wr && !idle0);
	c_pulse: cover property ($rose(out_q[0]) && phigh_ff[0] != '0);
endmodule // fds_top

/* tb/fds_clk_sink.sv */
module fds_clk_sink
	import fds_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        q,
	output logic      [31:0] high_len,
	output logic      [31:0] period
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        q_ff = 1'b0;
	logic [31:0] per_ff = 32'h0;
	logic [31:0] hi_ff = 32'h0;

	// Sampled mid-cycle where levels are settled; a period runs rise to rise
	always @(negedge clk) begin
		q_ff <= q;
		per_ff <= (q && !q_ff) ? 32'h1 : per_ff + 32'h1;
		hi_ff <= q ? hi_ff + 32'h1 : 32'h0;
		if (q && !q_ff)
			period <= per_ff;
		if (!q && q_ff)
			high_len <= hi_ff;
	end
endmodule // fds_clk_sink

/* tb/testbench.sv */
module testbench
	import fds_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        cfg_wr = 1'b0;
	logic        cfg_rd = 1'b0;
	logic [7:0]  cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0;
	logic [31:0] cfg_rdata;
	logic        cfg_rvalid;
	logic [3:0]  fb_tick;
	logic [7:0]  out_q;
	logic [7:0]  out_qn;
	logic [31:0] high_len;
	logic [31:0] period;
	logic        sel_q;
	int          failures = 0;
	int          num_checks = 0;
	int          cyc_ff = 0;
	int          tick_cnt_ff = 0;
	int          tk = 0;
	int          sel = 0;
	int          steps_tab [4] = '{1024, 128, 16, 1024};

	always #2 clk = ~clk;

	// Dual copies so the second path is compared against the first
	fds_top #(.STAGE_COPIES(2)) u_fds_top (
		.clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.fb_tick(fb_tick), .out_q(out_q), .out_qn(out_qn));

	assign sel_q = out_q[2*sel];
	fds_clk_sink u_fds_clk_sink (.clk(clk), .q(sel_q),
		.high_len(high_len), .period(period));

	// Free cycle and tick counters give phase without touching the design
	always @(posedge clk) begin
		cyc_ff <= cyc_ff + 1;
		if (fb_tick[tk] === 1'b1)
			tick_cnt_ff <= tick_cnt_ff + 1;
	end

	function automatic logic [7:0] ad(input logic st, input logic [1:0] u,
		input logic [3:0] r);
		return {1'b0, st, u, r};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge clk);
		cfg_rd = 1'b0;
		d = cfg_rdata;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	task automatic align(output int t0, output int n0);
		@(negedge clk iff fb_tick[tk] === 1'b1);
		t0 = cyc_ff;
		n0 = tick_cnt_ff;
	endtask

	// Waits for the n-th tick after the aligned one; watchdog covers hangs
	task automatic upto(input int t0, input int n0, input int n,
		output int e);
		@(negedge clk iff (fb_tick[tk] === 1'b1 && tick_cnt_ff == n0 + n));
		e = cyc_ff - t0;
	endtask

	task automatic t_regs();
		chk_rd(ad(0, 0, FDS_R_INT), 32'(FDS_INT_RST));
		chk(32'(cfg_rvalid), 32'h1);
		@(negedge clk);
		chk(32'(cfg_rvalid), 32'h0);
		chk_rd(ad(0, 0, FDS_R_FRAC_HI), 32'h0);
		chk_rd(ad(0, 2, FDS_R_RATE), 32'h0);
		chk_rd(ad(1, 3, FDS_R_ODIV), FDS_ODIV_RST);
		chk_rd(ad(1, 3, FDS_R_PHIGH), FDS_PHIGH_RST);
		wr(ad(1, 1, FDS_R_PHIGH), 32'hDEAD_BEEF);
		chk_rd(ad(1, 1, FDS_R_PHIGH), 32'hDEAD_BEEF);
		wr(8'h80, 32'hFFFF_FFFF);
		chk_rd(8'h80, 32'h0);
	endtask

	task automatic t_frac();
		int t0, n0, e;
		tk = 0;
		align(t0, n0);
		upto(t0, n0, 8, e);
		chk(32'(e), 32'h0000_00A0);
		wr(ad(0, 0, FDS_R_FRAC_HI), 32'h0000_0200);
		repeat (60) @(negedge clk);
		align(t0, n0);
		upto(t0, n0, 8, e);
		chk(32'(e), 32'h0000_00A2);
		wr(ad(0, 0, FDS_R_FRAC_HI), 32'h0);
	endtask

	// Shift of 8000 ps is just under two synth cycles over the whole step
	task automatic t_fine(input logic [1:0] rate, input logic [31:0] ps,
		input bit twice, input int steps, input int adv);
		logic [31:0] d;
		int t0, n0, b0, e, i;
		wr(ad(0, 0, FDS_R_RATE), {30'h0, rate});
		align(t0, n0);
		wr(ad(0, 0, FDS_R_FINE), ps);
		if (twice)
			wr(ad(0, 0, FDS_R_FINE), ps);
		b0 = cyc_ff;
		rd(ad(0, 0, FDS_R_STAT), d);
		chk(d, {30'h0, twice, 1'b1});
		// Busy drops for a cycle between queued steps, so poll pending too
		for (i = 0; i < 12000 && (d[0] === 1'b1 || d[1] === 1'b1); i++)
			rd(ad(0, 0, FDS_R_STAT), d);
		chk_rng(cyc_ff - b0, steps * 20 - 40, steps * 20 + 20);
		upto(t0, n0, steps + 8, e);
		chk_rng(e, (steps + 8) * 20 + adv - 1, (steps + 8) * 20 + adv + 1);
	endtask

	task automatic t_stage(input logic [1:0] s, input logic [1:0] oct,
		input logic [31:0] odiv, input logic [31:0] ph, input int per,
		input int hi);
		wr(ad(1, s, FDS_R_ODIV), odiv);
		wr(ad(1, s, FDS_R_PHIGH), ph);
		wr(ad(1, s, FDS_R_OCTRL), {30'h0, oct});
		sel = int'(s);
		repeat (3 * per + 20) @(negedge clk);
		chk(period, 32'(per));
		chk(high_len, 32'(hi));
		chk(32'(out_qn[2*sel]), 32'(out_q[2*sel] ^ oct[1]));
		chk(32'(out_q[2*sel+1]), 32'(out_q[2*sel]));
		chk(32'(out_qn[2*sel+1]), 32'(out_qn[2*sel]));
	endtask

	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Slow steps dominate: two of about 21k cycles, the rest is small
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	initial begin
		repeat (16) @(negedge clk);
		chk(32'({out_q, out_qn, fb_tick}), 32'h0);
		srst = 1'b0;
		t_regs();
		t_frac();
		tk = 0;
		for (int r = 0; r < 4; r++)
			t_fine(r[1:0], 32'hFFFF_E0C0, 1'b0, steps_tab[r], -2);
		t_fine(FDS_RATE_FAST, 32'h0000_1F40, 1'b0, 16, 2);
		t_fine(FDS_RATE_FAST, 32'hFFFF_F060, 1'b1, 16, -2);
		wr(ad(0, 0, FDS_R_INT), 32'h0000_000E);
		wr(ad(0, 1, FDS_R_INT), 32'h0000_000F);
		wr(ad(0, 2, FDS_R_INT), 32'h0000_0010);
		wr(ad(0, 3, FDS_R_INT), 32'h0000_0011);
		t_stage(2'h0, 2'h0, 32'h4, 32'h0, 56, 28);
		t_stage(2'h0, 2'h1, 32'h5, 32'h0, 75, 30);
		t_stage(2'h1, 2'h1, 32'h6, 32'h1, 90, 15);
		t_stage(2'h2, 2'h0, 32'h3, 32'h2, 48, 32);
		t_stage(2'h3, 2'h0, 32'h4, 32'h0, 64, 32);
		t_stage(2'h3, 2'h3, 32'h2, 32'h1, 34, 17);
		report_and_stop();
	end
endmodule // testbench
